// [rtl/ccpc_top.sv]
// Operation
// - On the main clock the divider bits give 00 -> /64, 10 -> /8, 11 -> /4.
// - With the source bit set the CPU runs from subsystem clock / 4, div 11.
// - Power bits decode 00 normal, 01 idle, 10 stop; set by instructions.
// - Idle and stop are entered whatever the bank enable flag holds.
// - Stop/source bits 00 main on, 01 sub with main on, 11 sub main off.
// - The clock-select register takes single-bit writes to bits 0 and 3.
// - On the main clock the oscillator-off bit does not stop oscillation.
// - Nothing inside stops the subsystem oscillator.
// - After a rewrite the old clock runs on for a set count of cycles.
// - After reset 31.3 ms stabilisation, then run on main clock / 64.
// - Latency 1 from /64, 8 from /8, 16 from /4, 32 to or from sub; sub only via /4.
// - The oscillator-off bit never puts the device into stop mode.
`timescale 1ns/1ps
module ccpc_top
	import ccpc_pkg::*;
#(
	parameter int STAB_CYCLES = STAB_CYC
)
(
	input  wire logic     core_clk_i,
	input  wire logic     sys_rst_i,
	input  wire logic     main_osc_clock_i,
	input  wire logic     sub_osc_clock_i,
	input  wire ccpc_wr_t reg_wr_i,
	input  wire logic     idle_instr_i,
	input  wire logic     stop_instr_i,
	input  wire logic     wake_i,
	input  wire logic     bank_enable_flag_i,
	output logic          cpu_clk_o,
	output logic          mc_tick_o,
	output logic          cpu_run_o,
	output logic          idle_mode_o,
	output logic          stop_mode_o,
	output logic          main_osc_en_o,
	output logic          sub_osc_en_o,
	output logic          sub_active_o
);

	// ==========================================================
	// Oscillator pin synchronisers
	logic [2:0] main_sync;
	logic [2:0] sub_sync;
	logic       main_lvl;
	logic       sub_lvl;
	logic       main_rise;
	logic       sub_rise;

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			main_sync <= 3'h0;
			sub_sync  <= 3'h0;
			main_lvl  <= 1'b0;
			sub_lvl   <= 1'b0;
		end
		else
		begin
			main_sync <= {main_sync[1:0], main_osc_clock_i};
			sub_sync  <= {sub_sync[1:0], sub_osc_clock_i};
			if (main_sync[2] == main_sync[1])
				main_lvl <= main_sync[2];
			if (sub_sync[2] == sub_sync[1])
				sub_lvl <= sub_sync[2];
		end
	end

	assign main_rise = (main_sync[2] == main_sync[1]) && main_sync[2]
		&& !main_lvl;
	assign sub_rise  = (sub_sync[2] == sub_sync[1]) && sub_sync[2]
		&& !sub_lvl;

	// ==========================================================
	// Switch legality and latency
	function automatic logic sel_legal(ccpc_sel_t from, ccpc_sel_t to);
		return (from != to)
			&& !(to.sub && to.div != DIV4)
			&& !(from.sub && (to.sub || to.div != DIV4))
			&& !(to.sub && from.div != DIV4)
			&& !(!to.sub && to.div == 2'h1);
	endfunction

	function automatic logic [5:0] sel_lat(ccpc_sel_t from, ccpc_sel_t to);
		return (from.sub || to.sub) ? LAT_SUB
			: (from.div == DIV64) ? LAT_FROM_64
			: (from.div == DIV8) ? LAT_FROM_8 : LAT_FROM_4;
	endfunction

	// ==========================================================
	// Control state
	ccpc_state_t state,     next_state;
	logic [3:0]  pwr_reg,   next_pwr_reg;
	logic [3:0]  clk_reg,   next_clk_reg;
	ccpc_sel_t   act,       next_act;
	logic        pend,      next_pend;
	logic [5:0]  lat_cnt,   next_lat_cnt;
	logic [6:0]  edge_cnt,  next_edge_cnt;
	logic [19:0] stab_cnt,  next_stab_cnt;
	logic        tick,      next_tick;
	logic        next_cpu_clk;
	logic        next_osc_en;
	logic [6:0]  edges_mc;
	logic        src_edge;
	ccpc_sel_t   req;
	logic        sel_wr;

	always_comb
	begin
		next_state    = state;
		next_pwr_reg  = pwr_reg;
		next_clk_reg  = clk_reg;
		next_act      = act;
		next_pend     = pend;
		next_lat_cnt  = lat_cnt;
		next_edge_cnt = edge_cnt;
		next_stab_cnt = stab_cnt;
		next_tick     = 1'b0;
		req           = act;

		if (act.sub)
			edges_mc = EDGES_4;
		else if (act.div == DIV64)
			edges_mc = EDGES_64;
		else if (act.div == DIV8)
			edges_mc = EDGES_8;
		else
			edges_mc = EDGES_4;
		src_edge = act.sub ? sub_rise : main_rise;

		// Register writes
		if (reg_wr_i.wr4 && reg_wr_i.addr == ADDR_PWR)
			next_pwr_reg[1:0] = reg_wr_i.data[1:0];
		if (reg_wr_i.wr1 && reg_wr_i.addr == ADDR_CLK
			&& (reg_wr_i.bitsel == CLK_SRC_BIT
			|| reg_wr_i.bitsel == CLK_OSC_OFF_BIT))
			next_clk_reg[reg_wr_i.bitsel] = reg_wr_i.data[0];
		if (reg_wr_i.wr1 && reg_wr_i.addr == ADDR_PWR)
			next_pwr_reg = pwr_reg;

		// Power-down instructions, bank flag not consulted
		if (state == ST_RUN && stop_instr_i)
			next_pwr_reg[PWR_STOP_BIT] = 1'b1;
		else if (state == ST_RUN && idle_instr_i)
			next_pwr_reg[PWR_IDLE_BIT] = 1'b1;

		// Pending switch held until latency runs out
		req = '{sub: next_clk_reg[0], div: next_pwr_reg[1:0]};
		sel_wr = next_pwr_reg[1:0] != pwr_reg[1:0]
			|| next_clk_reg[0] != clk_reg[0];
		if (sel_wr)
		begin
			next_pend    = sel_legal(act, req);
			next_lat_cnt = sel_lat(act, req);
		end

		case (state)
			ST_WAIT:
			begin
				next_edge_cnt = 7'h00;
				if (stab_cnt == 20'h0_0000)
					next_state = ST_RUN;
				else
					next_stab_cnt = stab_cnt - 20'h0_0001;
			end
			ST_RUN:
			begin
				if (src_edge)
				begin
					if (edge_cnt == edges_mc - 7'h01)
					begin
						next_edge_cnt = 7'h00;
						next_tick     = 1'b1;
						// A write in this cycle restarts the count
						if (pend && !sel_wr && lat_cnt <= 6'h01)
						begin
							next_act  = req;
							next_pend = 1'b0;
						end
						else if (pend && !sel_wr)
							next_lat_cnt = lat_cnt - 6'h01;
					end
					else
						next_edge_cnt = edge_cnt + 7'h01;
				end
				if (next_pwr_reg[PWR_STOP_BIT])
					next_state = ST_STOP;
				else if (next_pwr_reg[PWR_IDLE_BIT])
					next_state = ST_IDLE;
			end
			ST_IDLE:
			begin
				if (wake_i)
				begin
					next_pwr_reg[3:2] = 2'h0;
					next_state        = ST_RUN;
				end
			end
			default:
			begin
				if (wake_i)
				begin
					next_pwr_reg[3:2] = 2'h0;
					next_stab_cnt     = 20'(STAB_CYCLES - 1);
					next_state        = act.sub ? ST_RUN : ST_WAIT;
				end
			end
		endcase

		next_cpu_clk = (next_state == ST_RUN)
			&& (next_edge_cnt < {1'b0, edges_mc[6:1]});
		// Main oscillator gated in stop, or when the sub clock runs with bit 3 set
		next_osc_en  = (next_state != ST_STOP)
			&& !(next_clk_reg[3] && next_act.sub);
	end

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			state         <= ST_WAIT;
			pwr_reg       <= PWR_RESET;
			clk_reg       <= CLK_RESET;
			act           <= SEL_RESET;
			pend          <= 1'b0;
			lat_cnt       <= 6'h00;
			edge_cnt      <= 7'h00;
			stab_cnt      <= 20'(STAB_CYCLES - 1);
			tick          <= 1'b0;
			cpu_clk_o     <= 1'b0;
			mc_tick_o     <= 1'b0;
			cpu_run_o     <= 1'b0;
			idle_mode_o   <= 1'b0;
			stop_mode_o   <= 1'b0;
			main_osc_en_o <= 1'b1;
			sub_osc_en_o  <= 1'b1;
			sub_active_o  <= 1'b0;
		end
		else
		begin
			state         <= next_state;
			pwr_reg       <= next_pwr_reg;
			clk_reg       <= next_clk_reg;
			act           <= next_act;
			pend          <= next_pend;
			lat_cnt       <= next_lat_cnt;
			edge_cnt      <= next_edge_cnt;
			stab_cnt      <= next_stab_cnt;
			tick          <= next_tick;
			cpu_clk_o     <= next_cpu_clk;
			mc_tick_o     <= next_tick;
			cpu_run_o     <= next_state == ST_RUN;
			idle_mode_o   <= next_state == ST_IDLE;
			stop_mode_o   <= next_state == ST_STOP;
			main_osc_en_o <= next_osc_en;
			sub_osc_en_o  <= 1'b1;
			sub_active_o  <= next_act.sub;
		end
	end

	// ==========================================================
	// Checks
	sequence s_idle_req;
		state == ST_RUN && idle_instr_i && !stop_instr_i;
	endsequence
	sequence s_idle_entered;
		idle_mode_o && !cpu_run_o;
	endsequence

	property p_idle_entry;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		s_idle_req |=> s_idle_entered;
	endproperty
	a_idle_entry: assert property (p_idle_entry)
		else $error("idle instruction did not enter idle");

	property p_bank_flag_free;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(state == ST_RUN && stop_instr_i && !bank_enable_flag_i)
			|=> stop_mode_o ##0 !main_osc_en_o;
	endproperty
	a_bank_flag_free: assert property (p_bank_flag_free)
		else $error("stop not entered with bank flag low");

	property p_reset_sel;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		$past(sys_rst_i) |-> act == SEL_RESET && !cpu_run_o;
	endproperty
	a_reset_sel: assert property (p_reset_sel)
		else $error("reset did not select main clock div 64");

	property p_sub_div4;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		act.sub |-> act.div == DIV4;
	endproperty
	a_sub_div4: assert property (p_sub_div4)
		else $error("subsystem clock with divider not 11");

	property p_osc_bit_main;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(clk_reg[3] && !next_act.sub && next_state != ST_STOP)
			|=> main_osc_en_o && !stop_mode_o;
	endproperty
	a_osc_bit_main: assert property (p_osc_bit_main)
		else $error("oscillator-off bit acted on main clock");

	property p_sub_osc_off;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(act.sub && clk_reg[3]) |-> !main_osc_en_o;
	endproperty
	a_sub_osc_off: assert property (p_sub_osc_off)
		else $error("main oscillator not stopped on sub clock");

	property p_sub_osc_on;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		##1 sub_osc_en_o;
	endproperty
	a_sub_osc_on: assert property (p_sub_osc_on)
		else $error("subsystem oscillator disabled");

	property p_switch_boundary;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		$changed(act) |-> tick && $past(pend);
	endproperty
	a_switch_boundary: assert property (p_switch_boundary)
		else $error("clock source changed off a cycle boundary");

	property p_write_delayed;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(reg_wr_i.wr4 && reg_wr_i.addr == ADDR_PWR && !pend)
			|=> act == $past(act);
	endproperty
	a_write_delayed: assert property (p_write_delayed)
		else $error("selection took effect without latency");

	property p_nibble_clk;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(reg_wr_i.wr4 && !reg_wr_i.wr1 && reg_wr_i.addr == ADDR_CLK)
			|=> clk_reg == $past(clk_reg);
	endproperty
	a_nibble_clk: assert property (p_nibble_clk)
		else $error("clock-select register took a nibble write");

	property p_div64_latency;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(pend && !act.sub && act.div == DIV64 && lat_cnt == LAT_FROM_64
			&& next_tick && !sel_wr && state == ST_RUN)
			|=> act != $past(act);
	endproperty
	a_div64_latency: assert property (p_div64_latency)
		else $error("div 64 switch not made after one cycle");

	property p_div8_span;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(mc_tick_o && !act.sub && act.div == DIV8 && $stable(act))
			|-> $past(edge_cnt, 2) == EDGES_8 - 7'h01
			|| $past(edge_cnt, 2) == 7'h00;
	endproperty
	a_div8_span: assert property (p_div8_span)
		else $error("div 8 machine cycle length wrong");

endmodule // ccpc_top

// [common/ccpc_pkg.sv]
package ccpc_pkg;

	// ==========================================================
	// Register map (bank 15 nibble addresses)
	localparam logic [11:0] ADDR_PWR        = 12'h0FB3;
	localparam logic [11:0] ADDR_CLK        = 12'h0FB7;
	localparam logic [3:0]  PWR_RESET       = 4'h0;
	localparam logic [3:0]  CLK_RESET       = 4'h0;
	localparam int          PWR_IDLE_BIT    = 2;
	localparam int          PWR_STOP_BIT    = 3;
	localparam logic [1:0]  CLK_SRC_BIT     = 2'h0;
	localparam logic [1:0]  CLK_OSC_OFF_BIT = 2'h3;

	// ==========================================================
	// Divider codes and their oscillator edges per machine cycle
	localparam logic [1:0] DIV64     = 2'h0;
	localparam logic [1:0] DIV8      = 2'h2;
	localparam logic [1:0] DIV4      = 2'h3;
	localparam logic [6:0] EDGES_64  = 7'h40;
	localparam logic [6:0] EDGES_8   = 7'h08;
	localparam logic [6:0] EDGES_4   = 7'h04;

	// ==========================================================
	// Switch latencies in machine cycles
	localparam logic [5:0] LAT_FROM_64 = 6'h01;
	localparam logic [5:0] LAT_FROM_8  = 6'h08;
	localparam logic [5:0] LAT_FROM_4  = 6'h10;
	localparam logic [5:0] LAT_SUB     = 6'h20;

	// ==========================================================
	// Oscillation stabilisation after reset, or after stop release on the main clock
	localparam int CLK_PERIOD_NS = 50;
	localparam int STAB_TIME_NS  = 31_300_000;
	localparam int STAB_CYC      =
		(STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Types
	typedef struct packed
	{
		logic       sub;
		logic [1:0] div;
	} ccpc_sel_t;

	localparam ccpc_sel_t SEL_RESET = '{sub: 1'b0, div: DIV64};

	typedef struct packed
	{
		logic        wr4;
		logic        wr1;
		logic [11:0] addr;
		logic [1:0]  bitsel;
		logic [3:0]  data;
	} ccpc_wr_t;

	typedef enum logic [1:0]
	{
		ST_WAIT = 2'b00,
		ST_RUN  = 2'b01,
		ST_IDLE = 2'b11,
		ST_STOP = 2'b10
	} ccpc_state_t;

endpackage

// [verif/ccpc_cpu_model.sv]
`timescale 1ns/1ps
module ccpc_cpu_model
	import ccpc_pkg::*;
(
	input  wire logic clk_i,
	output ccpc_wr_t  reg_wr_o,
	output logic      idle_o,
	output logic      stop_o,
	output logic      wake_o
);
	// ==========================================================
	// Core side of the register write port and power instructions
	initial
	begin
		reg_wr_o = '0;
		idle_o = 1'b0;
		stop_o = 1'b0;
		wake_o = 1'b0;
	end

	// One-cycle strobe; released fields turn over so stale values show
	task automatic send(input ccpc_wr_t w);
		@(negedge clk_i);
		reg_wr_o = w;
		@(negedge clk_i);
		reg_wr_o = '{wr4: 1'b0, wr1: 1'b0, addr: ~w.addr,
			bitsel: ~w.bitsel, data: ~w.data};
	endtask

	task automatic wr_nib(input logic [11:0] a, input logic [3:0] d);
		send('{wr4: 1'b1, wr1: 1'b0, addr: a, bitsel: 2'h0, data: d});
	endtask

	task automatic wr_bit(input logic [1:0] b, input logic v);
		send('{wr4: 1'b0, wr1: 1'b1, addr: ADDR_CLK, bitsel: b,
			data: {3'h0, v}});
	endtask

	// Power instruction pulses: 0 idle, 1 stop, 2 wake
	task automatic pulse(input int which);
		@(negedge clk_i);
		idle_o = (which == 0);
		stop_o = (which == 1);
		wake_o = (which == 2);
		@(negedge clk_i);
		idle_o = 1'b0;
		stop_o = 1'b0;
		wake_o = 1'b0;
	endtask
endmodule // ccpc_cpu_model

// [verif/tb.sv]
`timescale 1ns/1ps
module tb
	import ccpc_pkg::*;
;
	localparam int STAB = 20;
	logic     core_clk_i = 1'b0;
	logic     sys_rst_i = 1'b1;
	logic     main_raw = 1'b0;
	logic     sub_raw = 1'b0;
	logic     bank_flag = 1'b0;
	ccpc_wr_t reg_wr;
	logic     idle_i, stop_i, wake_i;
	logic     cpu_clk_o, mc_tick_o, cpu_run_o, idle_mode_o, stop_mode_o;
	logic     main_osc_en_o, sub_osc_en_o, sub_active_o;
	int       failures = 0;
	int       check_count = 0;
	int       cycles = 0;
	int       n;

	// ==========================================================
	// Clocks; stopped main oscillator input reads ground
	always #25 core_clk_i = ~core_clk_i;
	initial
	begin
		#13;
		forever #200 main_raw = ~main_raw;
	end
	always #2000 sub_raw = ~sub_raw;

	ccpc_cpu_model cpu_inst (.clk_i(core_clk_i), .reg_wr_o(reg_wr),
		.idle_o(idle_i), .stop_o(stop_i), .wake_o(wake_i));

	ccpc_top #(.STAB_CYCLES(STAB)) ccpc_top_inst (
		.core_clk_i         (core_clk_i),
		.sys_rst_i          (sys_rst_i),
		.main_osc_clock_i   (main_raw & (main_osc_en_o !== 1'b0)),
		.sub_osc_clock_i    (sub_raw),
		.reg_wr_i           (reg_wr),
		.idle_instr_i       (idle_i),
		.stop_instr_i       (stop_i),
		.wake_i             (wake_i),
		.bank_enable_flag_i (bank_flag),
		.cpu_clk_o          (cpu_clk_o),
		.mc_tick_o          (mc_tick_o),
		.cpu_run_o          (cpu_run_o),
		.idle_mode_o        (idle_mode_o),
		.stop_mode_o        (stop_mode_o),
		.main_osc_en_o      (main_osc_en_o),
		.sub_osc_en_o       (sub_osc_en_o),
		.sub_active_o       (sub_active_o)
	);

	// ==========================================================
	// Checking helpers
	task automatic chk(input bit ok, input string msg);
		check_count++;
		if (!ok)
		begin
			failures++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask

	task automatic wrap_up;
		if (failures == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Core cycles between two ticks, and how many had the CPU clock high
	task automatic mc_period(output int p, output int h);
		@(negedge core_clk_i);
		while (mc_tick_o !== 1'b1)
			@(negedge core_clk_i);
		p = 0;
		h = 0;
		do
		begin
			@(negedge core_clk_i);
			p++;
			if (cpu_clk_o === 1'b1)
				h++;
		end
		while (mc_tick_o !== 1'b1);
	endtask

	task automatic skip_mc(input int k, input int expect_p, input string m);
		int h;
		repeat (k) mc_period(n, h);
		chk(n >= expect_p - 1 && n <= expect_p + 1, m);
		chk(h == expect_p / 2, "cpu clock not high half a cycle");
	endtask

	always @(posedge core_clk_i)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			failures++;
			wrap_up();
		end
	end

	// ==========================================================
	// Test sequence
	initial
	begin
		repeat (4) @(negedge core_clk_i);
		chk(main_osc_en_o === 1'b1 && sub_osc_en_o === 1'b1, "rst osc");
		chk(cpu_run_o === 1'b0, "run in reset");
		sys_rst_i = 1'b0;
		repeat (STAB - 2) @(negedge core_clk_i);
		chk(cpu_run_o === 1'b0, "run before stabilisation");
		repeat (6) @(negedge core_clk_i);
		chk(cpu_run_o === 1'b1, "no run after stabilisation");
		skip_mc(2, 512, "div64 period");
		cpu_inst.wr_nib(ADDR_PWR, 4'h3);
		skip_mc(3, 32, "div4 period");
		cpu_inst.wr_nib(ADDR_PWR, 4'h2);
		skip_mc(8, 32, "div4 left early");
		skip_mc(12, 64, "div8 period");
		cpu_inst.wr_nib(ADDR_CLK, 4'h1);
		cpu_inst.wr_bit(2'h1, 1'b1);
		cpu_inst.wr_bit(2'h0, 1'b1);
		skip_mc(40, 64, "sub from div8");
		chk(sub_active_o === 1'b0, "sub taken illegally");
		cpu_inst.wr_bit(2'h0, 1'b0);
		cpu_inst.wr_nib(ADDR_PWR, 4'h3);
		skip_mc(12, 32, "div4 again");
		cpu_inst.wr_bit(2'h3, 1'b1);
		skip_mc(4, 32, "main stopped by bit");
		chk(main_osc_en_o === 1'b1, "osc off on main");
		chk(stop_mode_o === 1'b0, "bit entered stop");
		cpu_inst.wr_bit(2'h3, 1'b0);
		cpu_inst.wr_bit(2'h0, 1'b1);
		skip_mc(40, 320, "sub period");
		chk(sub_active_o === 1'b1, "sub not active");
		cpu_inst.wr_bit(2'h3, 1'b1);
		repeat (4) @(negedge core_clk_i);
		chk(main_osc_en_o === 1'b0, "main not stopped");
		chk(sub_osc_en_o === 1'b1, "sub stopped");
		bank_flag = 1'b1;
		cpu_inst.pulse(0);
		chk(idle_mode_o === 1'b1 && cpu_run_o === 1'b0, "idle");
		chk(cpu_clk_o === 1'b0, "cpu clock runs in idle");
		cpu_inst.pulse(2);
		repeat (4) @(negedge core_clk_i);
		chk(cpu_run_o === 1'b1 && idle_mode_o === 1'b0, "idle wake");
		cpu_inst.wr_bit(2'h3, 1'b0);
		skip_mc(2, 320, "sub after osc on");
		cpu_inst.wr_bit(2'h0, 1'b0);
		skip_mc(40, 32, "back to main div4");
		chk(sub_active_o === 1'b0, "still sub");
		cpu_inst.wr_nib(ADDR_PWR, 4'h2);
		cpu_inst.wr_nib(ADDR_PWR, 4'h1);
		skip_mc(20, 32, "div code 01 kept old switch");
		bank_flag = 1'b0;
		cpu_inst.pulse(1);
		chk(stop_mode_o === 1'b1 && main_osc_en_o === 1'b0, "stop");
		chk(sub_osc_en_o === 1'b1, "sub stopped in stop");
		cpu_inst.pulse(2);
		chk(cpu_run_o === 1'b0, "no wait after stop");
		repeat (STAB + 6) @(negedge core_clk_i);
		chk(cpu_run_o === 1'b1 && stop_mode_o === 1'b0, "stop wake");
		wrap_up();
	end
endmodule // tb
